// ### shared/fpsc_pkg.sv
// Purpose: shared constants and types for the fan pwm start-up controller
// Assumes: commands are unsigned codes on the same scale as the ramp
// Notes:   all windows are counted in ramp periods
package fpsc_pkg;
	localparam int CMD_W          = 8;
	localparam int STARTUP_TICKS  = 32;
	localparam int RECOVER_PULSES = 16;
	localparam int WIN_W          = 6;
	localparam int PCNT_W         = 6;
	localparam logic [CMD_W-1:0] RAMP_BOTTOM = 8'h00;
	localparam logic [CMD_W-1:0] RAMP_TOP    = 8'hff;
	localparam logic [2:0] SYNC_RESET  = 3'h0;

	typedef enum {ST_SHUTDOWN, ST_START1, ST_START2, ST_RUN, ST_FAULT} fpsc_state_t;

	typedef struct packed
	{
		logic [CMD_W-1:0] temp_command;
		logic [CMD_W-1:0] min_speed_command;
	} fpsc_cmd_t;
endpackage : fpsc_pkg

// ### verilog/fpsc_ramp.sv
// Purpose: sawtooth ramp counter with a one-cycle wrap tick
// Assumes: ramp spans RAMP_BOTTOM to RAMP_TOP, one step per clock
// Notes:   runs freely, held at the bottom while shutdown
`timescale 1ns/1ps
`default_nettype none
module fpsc_ramp
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// control
	input  wire logic                       hold,
	// ramp
	output logic [fpsc_pkg::CMD_W-1:0]      ramp,
	output logic                            tick
);
	import fpsc_pkg::*;
	logic [CMD_W-1:0] ramp_reg;
	logic [CMD_W-1:0] ramp_next;

	assign ramp_next = hold ? RAMP_BOTTOM : (ramp_reg == RAMP_TOP ? RAMP_BOTTOM : ramp_reg + 8'h01);
	assign ramp      = ramp_reg;
	assign tick      = !hold && (ramp_reg == RAMP_TOP);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ramp_reg <= RAMP_BOTTOM;
		else
			ramp_reg <= ramp_next;
	end

	a_tick_wrap: assert property (@(posedge clk) disable iff (!nrst)
		tick |=> ramp_reg == RAMP_BOTTOM) else $error("ramp did not wrap after tick");
endmodule : fpsc_ramp
`default_nettype wire

// ### verilog/fpsc_core.sv
// Purpose: fan pwm drive with start-up timer, retry and fan fault
// Assumes: fan_pulse and shutdown come from pins; commands are already digital
// Notes:   one ramp period is one pwm cycle
//
// Functional notes
// - duty spans 0 to 254 of 256 clocks, then fully on at code top, at a fixed frequency.
// - the effective command is the larger of temperature and minimum-speed commands.
// - drive is high while the effective command is above the ramp; top means full duty.
// - both commands use the same scale so equal codes give equal duty.
// - after reset or leaving shutdown drive stays high for 32 pwm cycles.
// - a fan pulse seen during start-up leads to normal pwm when the period ends.
// - with no pulse in the first start-up period a second full-drive period follows.
// - with no pulse in the second period the active-low fault output goes low.
// - shutdown holds drive low and fault released for as long as it lasts.
// - release from shutdown restarts the full power-up sequence.
// - drive is active high so full duty means the fan at full speed.
// - in fault, drive stays high until 16 pulses fall in a 32-cycle window, then pwm resumes.
`timescale 1ns/1ps
`default_nettype none
module fpsc_core
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// commands
	input  wire fpsc_pkg::fpsc_cmd_t cmd,
	// pins
	input  wire logic              shutdown_req,
	input  wire logic              fan_pulse,
	// outputs
	output logic                   pwm_drive,
	output logic                   fault_n_o,
	output logic                   fault_n_oe,
	output logic [2:0]             state_code
);
	import fpsc_pkg::*;

	logic [2:0]          fan_sync_reg;
	logic [2:0]          sd_sync_reg;
	logic                fan_level_reg;
	logic                sd_level_reg;
	fpsc_state_t         state_reg;
	fpsc_state_t         state_next;
	logic [WIN_W-1:0]    win_reg;
	logic [WIN_W-1:0]    win_next;
	logic [PCNT_W-1:0]   pcnt_reg;
	logic [PCNT_W-1:0]   pcnt_next;
	logic                seen_reg;
	logic                seen_next;
	logic                drive_reg;
	logic                drive_next;
	logic                fault_reg;
	logic [CMD_W-1:0]    ramp;
	logic                tick;
	wire  [CMD_W-1:0]    eff_cmd;
	wire                 fan_edge;
	wire                 win_end;
	wire                 pwm_level;

	function automatic logic [CMD_W-1:0] max_cmd(input logic [CMD_W-1:0] a,
		input logic [CMD_W-1:0] b);
		max_cmd = (a > b) ? a : b;
	endfunction : max_cmd

	fpsc_ramp u_ramp
	(
		.clk  (clk),
		.nrst (nrst),
		.hold (sd_level_reg),
		.ramp (ramp),
		.tick (tick)
	);

	// command select and compare
	assign eff_cmd   = max_cmd(cmd.temp_command, cmd.min_speed_command);
	assign pwm_level = (eff_cmd == RAMP_TOP) || (eff_cmd > ramp);
	assign fan_edge  = (fan_sync_reg[2] == fan_sync_reg[1]) && fan_sync_reg[1] && !fan_level_reg;
	assign win_end   = tick && (win_reg == WIN_W'(STARTUP_TICKS - 1));

	// input synchronisers, a change counts once stages two and three agree
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fan_sync_reg  <= SYNC_RESET;
			sd_sync_reg   <= SYNC_RESET;
			fan_level_reg <= 1'b0;
			sd_level_reg  <= 1'b0;
		end
		else
		begin
			fan_sync_reg <= {fan_sync_reg[1:0], fan_pulse};
			sd_sync_reg  <= {sd_sync_reg[1:0], shutdown_req};
			if (fan_sync_reg[2] == fan_sync_reg[1])
				fan_level_reg <= fan_sync_reg[1];
			if (sd_sync_reg[2] == sd_sync_reg[1])
				sd_level_reg <= sd_sync_reg[1];
		end
	end

	// sequencing
	always_comb
	begin
		state_next = state_reg;
		win_next   = tick ? win_reg + WIN_W'(1) : win_reg;
		pcnt_next  = (fan_edge && pcnt_reg != PCNT_W'(RECOVER_PULSES)) ? pcnt_reg + PCNT_W'(1) : pcnt_reg;
		seen_next  = seen_reg || fan_edge;
		if (win_end)
		begin
			win_next  = '0;
			pcnt_next = '0;
			seen_next = 1'b0;
		end
		case (state_reg)
			ST_SHUTDOWN:
			begin
				win_next  = '0;
				pcnt_next = '0;
				seen_next = 1'b0;
				if (!sd_level_reg)
					state_next = ST_START1;
			end
			ST_START1:
				if (win_end)
					state_next = (seen_reg || fan_edge) ? ST_RUN : ST_START2;
			ST_START2:
				if (win_end)
					state_next = (seen_reg || fan_edge) ? ST_RUN : ST_FAULT;
			ST_RUN:
			begin
				win_next  = '0;
				pcnt_next = '0;
				seen_next = 1'b0;
			end
			ST_FAULT:
				if (pcnt_next == PCNT_W'(RECOVER_PULSES) && !win_end)
					state_next = ST_RUN;
				else if (win_end && pcnt_reg + PCNT_W'(fan_edge) >= PCNT_W'(RECOVER_PULSES))
					state_next = ST_RUN;
			default:
				state_next = ST_SHUTDOWN;
		endcase
		if (sd_level_reg)
			state_next = ST_SHUTDOWN;
	end

	assign drive_next = (state_next == ST_SHUTDOWN) ? 1'b0 :
		(state_next == ST_RUN) ? pwm_level : 1'b1;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_START1;
			win_reg   <= '0;
			pcnt_reg  <= '0;
			seen_reg  <= 1'b0;
			drive_reg <= 1'b0;
			fault_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			win_reg   <= win_next;
			pcnt_reg  <= pcnt_next;
			seen_reg  <= seen_next;
			drive_reg <= drive_next;
			fault_reg <= (state_next == ST_FAULT);
		end
	end

	assign pwm_drive  = drive_reg;
	assign fault_n_o  = 1'b0;
	assign fault_n_oe = fault_reg;
	assign state_code = 3'(state_reg);

	// checks
	a_shutdown_low: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_SHUTDOWN |-> !drive_reg && !fault_reg) else $error("drive or fault active in shutdown");
	a_start_high: assert property (@(posedge clk) disable iff (!nrst)
		state_reg inside {ST_START1, ST_START2} && !win_end && !sd_level_reg
		|=> drive_reg) else $error("drive low during start-up");
	a_retry_once: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_START1 && win_end && !seen_reg && !fan_edge && !sd_level_reg
		|=> state_reg == ST_START2) else $error("no retry after silent start-up");
	a_fault_entry: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_START2 && win_end && !seen_reg && !fan_edge && !sd_level_reg
		|=> fault_reg) else $error("fault not raised after retry");
	a_start_to_run: assert property (@(posedge clk) disable iff (!nrst)
		state_reg inside {ST_START1, ST_START2} && win_end && seen_reg && !sd_level_reg
		|=> state_reg == ST_RUN) else $error("pulse seen but no pwm");
	a_fault_drive: assert property (@(posedge clk) disable iff (!nrst)
		fault_reg |-> drive_reg) else $error("drive low while in fault");
	a_run_compare: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_RUN && $past(state_reg) == ST_RUN && !$past(sd_level_reg)
		|-> drive_reg == $past(pwm_level)) else $error("pwm not following compare");
	a_full_duty: assert property (@(posedge clk) disable iff (!nrst)
		eff_cmd == RAMP_TOP && state_reg == ST_RUN && !sd_level_reg
		|=> drive_reg) else $error("full command not full duty");
	a_zero_duty: assert property (@(posedge clk) disable iff (!nrst)
		eff_cmd == RAMP_BOTTOM && state_reg == ST_RUN && !sd_level_reg
		|=> !drive_reg) else $error("zero command drove fan");
	a_release_start: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_SHUTDOWN && !sd_level_reg |=> state_reg == ST_START1) else $error("no restart");

	c_run: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_RUN);
	c_retry: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_START2);
	c_fault: cover property (@(posedge clk) disable iff (!nrst) fault_reg);
	c_recover: cover property (@(posedge clk) disable iff (!nrst) fault_reg ##1 !fault_reg && !sd_level_reg);
endmodule : fpsc_core
`default_nettype wire

// ### verification/fpsc_fan_model.sv
// Purpose: fan and current sense model facing the drive output
// Assumes: sense pulses flow only while the fan spins and is driven
// Notes:   sense line rests low without current
`timescale 1ns/1ps
`default_nettype none
module fpsc_fan_model
(
	// clock
	input  wire logic clk,
	// control
	input  wire logic spin_en,
	input  wire logic pwm_drive,
	// sense
	output logic      fan_pulse
);
	logic [6:0] ph_reg = 7'h00;
	always_ff @(posedge clk)
	begin
		ph_reg <= (ph_reg == 7'h63) ? 7'h00 : ph_reg + 7'h01;
	end
	// a high drive turns the transistor on, so current pulses appear
	assign fan_pulse = spin_en & pwm_drive & (ph_reg < 7'h14);
endmodule : fpsc_fan_model
`default_nettype wire

// ### verification/fan_pwm_startup_control_tb_top.sv
// Purpose: self-checking bench for the fan pwm start-up controller
// Assumes: 100 MHz clock, 256-clock pwm period
// Notes:   duty is the high count over any 256 clocks
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_startup_control_tb_top;
	import fpsc_pkg::*;
	typedef struct {int n; int hi; logic oe; logic [2:0] sc;} fpsc_note_t;
	logic       clk          = 1'b0;
	logic       nrst         = 1'b0;
	fpsc_cmd_t  cmd          = '0;
	logic       shutdown_req = 1'b0;
	logic       spin_en      = 1'b1;
	logic       fan_pulse;
	logic       pwm_drive;
	logic       fault_n_oe;
	logic       fault_n_o;
	logic [2:0] state_code;
	int         n_mismatch   = 0;
	int         checks       = 0;
	int         seed         = 61080;
	fpsc_note_t notes[$];

	always #5 clk = ~clk;

	fpsc_core u_dut (.clk(clk), .nrst(nrst), .cmd(cmd), .shutdown_req(shutdown_req),
		.fan_pulse(fan_pulse), .pwm_drive(pwm_drive), .fault_n_o(fault_n_o),
		.fault_n_oe(fault_n_oe), .state_code(state_code));
	fpsc_fan_model u_fan (.clk(clk), .spin_en(spin_en), .pwm_drive(pwm_drive),
		.fan_pulse(fan_pulse));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// note an expected high count and fault enable, wait for the watcher
	task automatic meas(input int n, input int hi, input logic oe, input logic [2:0] sc);
		notes.push_back('{n, hi, oe, sc});
		wait (notes.size() == 0);
		@(negedge clk);
	endtask : meas

	task automatic duty(input logic [7:0] t, input logic [7:0] m);
		logic [7:0] e;
		e = (t > m) ? t : m;
		cmd = {t, m};
		repeat (300) @(negedge clk);
		meas(256, (e == RAMP_TOP) ? 256 : int'(e), 1'b0, 3'h3);
	endtask : duty

	// watcher: counts drive high cycles, then compares with the oldest note
	initial
	begin
		fpsc_note_t nt;
		int hi;
		forever
		begin
			wait (notes.size() > 0);
			hi = 0;
			repeat (notes[0].n)
			begin
				@(posedge clk);
				#1;
				if (pwm_drive === 1'b1)
					hi++;
			end
			nt = notes[0];
			check(16'(hi), 16'(nt.hi));
			check({15'h0000, fault_n_oe}, {15'h0000, nt.oe});
			check({15'h0000, fault_n_oe ? fault_n_o : 1'b1}, {15'h0000, ~nt.oe});
			check({13'h0000, state_code}, {13'h0000, nt.sc});
			void'(notes.pop_front());
		end
	end

	initial
	begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		meas(8000, 8000, 1'b0, 3'h1);
		repeat (1000) @(negedge clk);
		duty(8'h00, 8'h00);
		duty(8'hff, 8'h00);
		duty(8'h00, 8'hff);
		duty(8'h80, 8'h40);
		duty(8'h40, 8'h80);
		duty(8'h80, 8'h80);
		repeat (4) duty(8'($random(seed)), 8'($random(seed)));
		spin_en = 1'b0;
		shutdown_req = 1'b1;
		repeat (10) @(negedge clk);
		meas(500, 0, 1'b0, 3'h0);
		shutdown_req = 1'b0;
		repeat (10) @(negedge clk);
		meas(16300, 16300, 1'b0, 3'h2);
		repeat (1000) @(negedge clk);
		meas(1000, 1000, 1'b1, 3'h4);
		spin_en = 1'b1;
		cmd = {8'h00, 8'h40};
		repeat (17000) @(negedge clk);
		meas(256, 64, 1'b0, 3'h3);
		spin_en = 1'b0;
		shutdown_req = 1'b1;
		repeat (10) @(negedge clk);
		shutdown_req = 1'b0;
		repeat (17500) @(negedge clk);
		meas(100, 100, 1'b1, 3'h4);
		shutdown_req = 1'b1;
		repeat (10) @(negedge clk);
		meas(300, 0, 1'b0, 3'h0);
		final_report();
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule : fan_pwm_startup_control_tb_top
`default_nettype wire
